// File: tcm_top.sv
// Eight-channel timer mode, run control and status register block
`timescale 1ns/100ps
module tcm_top (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [19:0] cpu_addr,
  input  wire logic [15:0] cpu_wdata,
  input  wire logic        cpu_wr,
  input  wire logic        cpu_rd,
  output logic      [15:0] cpu_rdata,
  input  wire logic [7:0]  timer_input_pin,
  input  wire logic        prescaled_clock_0,
  input  wire logic        prescaled_clock_1,
  input  wire logic        prescaled_clock_2,
  input  wire logic        prescaled_clock_3,
  output logic      [7:0]  channel_interrupt,
  output logic      [7:0]  channel_timer_output
);

  typedef struct packed {
    logic [7:0][15:0] mode_cfg;
    logic [15:0]      start_pend;
    logic [15:0]      enable;
    logic [15:0]      rdata;
  } tcm_regs_t;

  tcm_regs_t st;
  tcm_regs_t next_st;

  logic [7:0] pin_rise;
  logic [7:0] pin_fall;
  logic [7:0] valid_edge;
  logic [7:0] start_trig;
  logic [7:0] capture_trig;
  logic [7:0] tick;
  logic [7:0] sw_start;
  logic [7:0] ext_sel;
  logic [7:0] ovf_flag;
  logic [7:0] irq;
  logic [7:0] tout;
  logic [7:0] mode_hit;
  logic [7:0] ovf_hit;

  // Write mask of a channel's mode register
  function automatic logic [15:0] mode_wmask(input int ch);
    if (tcm_pkg::CCS_CH[ch]) begin
      mode_wmask = tcm_pkg::WMASK_CCS;
    end else begin
      mode_wmask = tcm_pkg::WMASK_PLAIN;
    end
  endfunction

  // Master bit as seen by the hardware
  function automatic logic is_master(input int ch, input logic [15:0] cfg);
    if (ch == 0) begin
      is_master = 1'b1;
    end else begin
      is_master = tcm_pkg::MASTER_CH[ch] && cfg[tcm_pkg::BIT11];
    end
  endfunction

  // Interrupt of the nearest master below a slave channel
  function automatic logic master_irq(input int ch, input logic [7:0][15:0] cfg,
                                      input logic [7:0] irqs);
    logic found;
    found      = 1'b0;
    master_irq = 1'b0;
    for (int k = 7; k >= 0; k--) begin
      if (k < ch && !found && is_master(k, cfg[k])) begin
        found      = 1'b1;
        master_irq = irqs[k];
      end
    end
  endfunction

  // Operation clock enable selected by the clock field
  function automatic logic op_clock(input int ch, input logic [1:0] cks,
                                    input logic [3:0] clks);
    case (cks)
      tcm_pkg::CKS_CLK0: op_clock = clks[0];
      tcm_pkg::CKS_CLK1: op_clock = clks[1];
      tcm_pkg::CKS_CLK2: op_clock = tcm_pkg::SPLIT_CH[ch] ? clks[2] : clks[0];
      tcm_pkg::CKS_CLK3: op_clock = tcm_pkg::SPLIT_CH[ch] ? clks[3] : clks[1];
      default:           op_clock = clks[0];
    endcase
  endfunction

  // Register address decode
  function automatic logic addr_in(input logic [19:0] a, input logic [19:0] lo,
                                   input logic [19:0] hi);
    addr_in = (a >= lo) && (a <= hi) && !a[0];
  endfunction

  genvar g;
  generate
    for (g = 0; g < tcm_pkg::NCH; g++) begin : g_ch
      tcm_insync u_sync (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (timer_input_pin[g]),
        .rise  (pin_rise[g]),
        .fall  (pin_fall[g])
      );

      tcm_chan u_chan (
        .clk           (clk),
        .rst_n         (rst_n),
        .enabled       (st.enable[g]),
        .sw_start      (sw_start[g]),
        .ext_start_sel (ext_sel[g]),
        .mode          (st.mode_cfg[g][tcm_pkg::MD_HI:tcm_pkg::MD_LO]),
        .md0           (st.mode_cfg[g][tcm_pkg::MD0_BIT]),
        .tick          (tick[g]),
        .start_trig    (start_trig[g]),
        .capture_trig  (capture_trig[g]),
        .ovf_flag      (ovf_flag[g]),
        .irq           (irq[g]),
        .tout          (tout[g])
      );
    end
  endgenerate

  // Trigger and count-clock selection per channel
  always_comb begin
    logic [1:0]  cis;
    logic [2:0]  sts;
    logic [15:0] cfg;
    cis          = '0;
    sts          = '0;
    cfg          = '0;
    valid_edge   = '0;
    start_trig   = '0;
    capture_trig = '0;
    tick         = '0;
    ext_sel      = '0;
    for (int n = 0; n < tcm_pkg::NCH; n++) begin
      cfg = st.mode_cfg[n];
      cis = cfg[tcm_pkg::CIS_HI:tcm_pkg::CIS_LO];
      sts = cfg[tcm_pkg::STS_HI:tcm_pkg::STS_LO];
      case (cis)
        tcm_pkg::CIS_FALL: valid_edge[n] = pin_fall[n];
        tcm_pkg::CIS_RISE: valid_edge[n] = pin_rise[n];
        default:           valid_edge[n] = pin_rise[n] | pin_fall[n];
      endcase
      case (sts)
        tcm_pkg::STS_EDGE: begin
          start_trig[n]   = valid_edge[n];
          capture_trig[n] = valid_edge[n];
        end
        tcm_pkg::STS_BOTH: begin
          // Code 11 measures high width, others low width
          start_trig[n]   = (cis == tcm_pkg::CIS_BOTH_HI) ? pin_rise[n] : pin_fall[n];
          capture_trig[n] = (cis == tcm_pkg::CIS_BOTH_HI) ? pin_fall[n] : pin_rise[n];
        end
        tcm_pkg::STS_MASTER: begin
          start_trig[n]   = master_irq(n, st.mode_cfg, irq);
          capture_trig[n] = master_irq(n, st.mode_cfg, irq);
        end
        default: begin
          start_trig[n]   = 1'b0;
          capture_trig[n] = 1'b0;
        end
      endcase
      ext_sel[n] = (sts != tcm_pkg::STS_SOFT);
      if (tcm_pkg::CCS_CH[n] && cfg[tcm_pkg::CCS_BIT]) begin
        tick[n] = valid_edge[n];
      end else begin
        tick[n] = op_clock(n, cfg[tcm_pkg::CKS_HI:tcm_pkg::CKS_LO],
                           {prescaled_clock_3, prescaled_clock_2,
                            prescaled_clock_1, prescaled_clock_0});
      end
    end
  end

  // Pending start bits reach the channels in the cycle they take effect
  always_comb begin
    sw_start = st.start_pend[7:0];
  end

  // Address hits
  always_comb begin
    mode_hit = '0;
    ovf_hit  = '0;
    for (int n = 0; n < tcm_pkg::NCH; n++) begin
      mode_hit[n] = (cpu_addr == tcm_pkg::MODE_BASE + 20'(2 * n));
      ovf_hit[n]  = (cpu_addr == tcm_pkg::OVF_BASE + 20'(2 * n));
    end
  end

  // Register file
  always_comb begin
    logic [15:0] wmask;
    wmask   = '0;
    next_st = st;
    // Pending starts become enable bits, then clear themselves
    next_st.enable     = st.enable | st.start_pend;
    next_st.start_pend = '0;
    if (cpu_wr) begin
      for (int n = 0; n < tcm_pkg::NCH; n++) begin
        if (mode_hit[n]) begin
          wmask = mode_wmask(n);
          if (st.enable[n]) begin
            wmask = wmask & tcm_pkg::WMASK_EDGE;
          end
          next_st.mode_cfg[n] = (st.mode_cfg[n] & ~wmask) | (cpu_wdata & wmask);
        end
      end
      if (cpu_addr == tcm_pkg::START_ADDR) begin
        next_st.start_pend = cpu_wdata & tcm_pkg::ENABLE_MASK;
      end
      if (cpu_addr == tcm_pkg::STOP_ADDR) begin
        next_st.enable = next_st.enable & ~(cpu_wdata & tcm_pkg::ENABLE_MASK);
      end
    end
    if (cpu_rd) begin
      next_st.rdata = tcm_pkg::RESET_VALUE;
      for (int n = 0; n < tcm_pkg::NCH; n++) begin
        if (mode_hit[n]) begin
          next_st.rdata = st.mode_cfg[n];
        end
        if (ovf_hit[n]) begin
          next_st.rdata = {15'h0000, ovf_flag[n]};
        end
      end
      if (cpu_addr == tcm_pkg::ENABLE_ADDR) begin
        next_st.rdata = st.enable;
      end
      // Start and stop registers read as zero
      if (cpu_addr == tcm_pkg::START_ADDR || cpu_addr == tcm_pkg::STOP_ADDR) begin
        next_st.rdata = tcm_pkg::RESET_VALUE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cpu_rdata            = st.rdata;
  assign channel_interrupt    = irq;
  assign channel_timer_output = tout;

endmodule

// File: tcm_pkg.sv
// Constants, field positions and codes for the timer channel mode block
package tcm_pkg;

  localparam int          NCH          = 8;
  localparam int          ADDR_W       = 20;
  localparam int          DATA_W       = 16;

  // Register map, 16-bit registers at 2-byte steps
  localparam logic [19:0] MODE_BASE    = 20'hf0190;
  localparam logic [19:0] MODE_LAST    = 20'hf019e;
  localparam logic [19:0] OVF_BASE     = 20'hf01a0;
  localparam logic [19:0] OVF_LAST     = 20'hf01ae;
  localparam logic [19:0] ENABLE_ADDR  = 20'hf01b0;
  localparam logic [19:0] START_ADDR   = 20'hf01b2;
  localparam logic [19:0] STOP_ADDR    = 20'hf01b4;

  localparam logic [15:0] RESET_VALUE  = 16'h0000;

  // Mode register fields
  localparam int          CKS_HI       = 15;
  localparam int          CKS_LO       = 14;
  localparam int          CCS_BIT      = 12;
  localparam int          BIT11        = 11;
  localparam int          STS_HI       = 10;
  localparam int          STS_LO       = 8;
  localparam int          CIS_HI       = 7;
  localparam int          CIS_LO       = 6;
  localparam int          MD_HI        = 3;
  localparam int          MD_LO        = 1;
  localparam int          MD0_BIT      = 0;

  // Writable bits: bits 13, 5, 4 always zero, bit 12 only where source select exists
  localparam logic [15:0] WMASK_PLAIN  = 16'hcfcf;
  localparam logic [15:0] WMASK_CCS    = 16'hd7cf;
  localparam logic [15:0] WMASK_EDGE   = 16'h00c0;

  // Channel groups
  localparam logic [7:0]  CCS_CH       = 8'ha1;
  localparam logic [7:0]  SPLIT_CH     = 8'h0a;
  localparam logic [7:0]  MASTER_CH    = 8'h54;

  // Enable status and start register layout
  localparam int          UPPER1_BIT   = 9;
  localparam int          UPPER3_BIT   = 11;
  localparam logic [15:0] ENABLE_MASK  = 16'h0aff;

  // Trigger source codes
  localparam logic [2:0]  STS_SOFT     = 3'h0;
  localparam logic [2:0]  STS_EDGE     = 3'h1;
  localparam logic [2:0]  STS_BOTH     = 3'h2;
  localparam logic [2:0]  STS_MASTER   = 3'h4;

  // Input edge codes
  localparam logic [1:0]  CIS_FALL     = 2'h0;
  localparam logic [1:0]  CIS_RISE     = 2'h1;
  localparam logic [1:0]  CIS_BOTH_LO  = 2'h2;
  localparam logic [1:0]  CIS_BOTH_HI  = 2'h3;

  // Operation clock codes
  localparam logic [1:0]  CKS_CLK0     = 2'h0;
  localparam logic [1:0]  CKS_CLK2     = 2'h1;
  localparam logic [1:0]  CKS_CLK1     = 2'h2;
  localparam logic [1:0]  CKS_CLK3     = 2'h3;

  // Operation mode codes (bits 3..1)
  localparam logic [2:0]  MD_INTERVAL  = 3'h0;
  localparam logic [2:0]  MD_CAPTURE   = 3'h2;
  localparam logic [2:0]  MD_EVENT     = 3'h3;
  localparam logic [2:0]  MD_ONECOUNT  = 3'h4;
  localparam logic [2:0]  MD_CAPONE    = 3'h6;

  localparam logic [15:0] COUNT_ZERO   = 16'h0000;
  localparam logic [15:0] COUNT_TOP    = 16'hffff;

endpackage

// File: tcm_insync.sv
// Three-stage input synchroniser with agreed-level edge detection
`timescale 1ns/100ps
module tcm_insync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic rise;
    logic fall;
  } tcm_sync_t;

  tcm_sync_t st;
  tcm_sync_t next_st;

  always_comb begin
    next_st      = st;
    next_st.s1   = pin;
    next_st.s2   = st.s1;
    next_st.s3   = st.s2;
    next_st.rise = 1'b0;
    next_st.fall = 1'b0;
    // Level moves only once stages two and three agree
    if (st.s2 == st.s3 && st.s3 != st.level) begin
      next_st.level = st.s3;
      next_st.rise  = st.s3;
      next_st.fall  = ~st.s3;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign rise = st.rise;
  assign fall = st.fall;

endmodule

// File: tcm_chan.sv
// One channel counter with start, capture and overflow handling
`timescale 1ns/100ps
module tcm_chan (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       enabled,
  input  wire logic       sw_start,
  input  wire logic       ext_start_sel,
  input  wire logic [2:0] mode,
  input  wire logic       md0,
  input  wire logic       tick,
  input  wire logic       start_trig,
  input  wire logic       capture_trig,
  output logic            ovf_flag,
  output logic            irq,
  output logic            tout
);

  typedef enum logic [1:0] {CH_IDLE, CH_ARMED, CH_COUNT} tcm_chst_t;

  typedef struct packed {
    tcm_chst_t   state;
    logic [15:0] count;
    logic        ovf_pend;
    logic        ovf;
    logic        irq;
    logic        tout;
  } tcm_ch_t;

  tcm_ch_t st;
  tcm_ch_t next_st;
  logic    count_up;
  logic    one_shot;
  logic    begin_cnt;

  always_comb begin
    count_up  = (mode == tcm_pkg::MD_CAPTURE) || (mode == tcm_pkg::MD_CAPONE);
    one_shot  = (mode == tcm_pkg::MD_ONECOUNT) || (mode == tcm_pkg::MD_CAPONE);
    begin_cnt = 1'b0;
    next_st     = st;
    next_st.irq = 1'b0;
    case (st.state)
      CH_IDLE: begin
        if (sw_start) begin
          if (one_shot && ext_start_sel) begin
            next_st.state = CH_ARMED;
          end else begin
            begin_cnt = 1'b1;
          end
        end
      end
      CH_ARMED: begin
        if (!enabled) begin
          next_st.state = CH_IDLE;
        end else if (start_trig || sw_start) begin
          begin_cnt = 1'b1;
        end
      end
      CH_COUNT: begin
        if (!enabled) begin
          next_st.state = CH_IDLE;
        end else if ((start_trig || sw_start) && mode == tcm_pkg::MD_ONECOUNT && md0) begin
          next_st.count = tcm_pkg::COUNT_TOP;
        end else if (capture_trig && count_up) begin
          next_st.ovf      = st.ovf_pend || (tick && st.count == tcm_pkg::COUNT_TOP);
          next_st.ovf_pend = 1'b0;
          next_st.count    = tcm_pkg::COUNT_ZERO;
          next_st.irq      = 1'b1;
          if (mode == tcm_pkg::MD_CAPONE) begin
            next_st.state = CH_ARMED;
          end
        end else if (tick) begin
          if (count_up) begin
            next_st.count = st.count + 16'h0001;
            if (st.count == tcm_pkg::COUNT_TOP) begin
              next_st.ovf_pend = 1'b1;
            end
          end else if (st.count == tcm_pkg::COUNT_ZERO) begin
            next_st.irq   = 1'b1;
            next_st.tout  = ~st.tout;
            next_st.count = tcm_pkg::COUNT_TOP;
            if (mode == tcm_pkg::MD_ONECOUNT) begin
              next_st.state = CH_ARMED;
            end
          end else begin
            next_st.count = st.count - 16'h0001;
          end
        end
      end
      default: begin
        next_st.state = CH_IDLE;
      end
    endcase
    if (begin_cnt) begin
      next_st.state    = CH_COUNT;
      next_st.count    = count_up ? tcm_pkg::COUNT_ZERO : tcm_pkg::COUNT_TOP;
      next_st.ovf_pend = 1'b0;
      // Start-time event only in interval and capture modes
      if (md0 && (mode == tcm_pkg::MD_INTERVAL || mode == tcm_pkg::MD_CAPTURE)) begin
        next_st.irq  = 1'b1;
        next_st.tout = ~st.tout;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st <= '{state: CH_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign ovf_flag = st.ovf;
  assign irq      = st.irq;
  assign tout     = st.tout;

endmodule

// File: tcm_assertions.sv
// Port-level checker for the timer channel mode block
`timescale 1ns/100ps
module tcm_assertions (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [19:0] cpu_addr,
  input wire logic [15:0] cpu_wdata,
  input wire logic        cpu_wr,
  input wire logic        cpu_rd,
  input wire logic [15:0] cpu_rdata,
  input wire logic [7:0]  channel_interrupt,
  input wire logic [7:0]  channel_timer_output
);
  localparam logic [19:0] ST = tcm_pkg::START_ADDR;
  localparam logic [19:0] SP = tcm_pkg::STOP_ADDR;
  localparam logic [19:0] EN = tcm_pkg::ENABLE_ADDR;
  logic rm;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  assign rm = cpu_rd && !cpu_addr[0] && cpu_addr >= tcm_pkg::MODE_BASE
    && cpu_addr <= tcm_pkg::MODE_LAST;

  a_reset_quiet: assert property ($rose(rst_n) |-> cpu_rdata == 16'h0000
    && channel_interrupt == 8'h00 && channel_timer_output == 8'h00)
    else $error("outputs not clear after reset");
  a_trig_reads_zero: assert property (cpu_rd && (cpu_addr == ST || cpu_addr == SP)
    |=> cpu_rdata == 16'h0000) else $error("trigger register read not zero");
  a_bit11_fixed: assert property (cpu_rd && cpu_addr inside {20'hf0190, 20'hf019a,
    20'hf019e} |=> !cpu_rdata[11]) else $error("fixed bit 11 reads one");
  a_mode_rsvd_zero: assert property (rm |=> cpu_rdata[13] == 1'b0
    && cpu_rdata[5:4] == 2'h0) else $error("reserved mode bits read one");
  a_src_bit_absent: assert property (rm && !tcm_pkg::CCS_CH[cpu_addr[3:1]]
    |=> !cpu_rdata[12]) else $error("source bit set on channel without it");
  a_ovf_one_bit: assert property (cpu_rd && cpu_addr >= tcm_pkg::OVF_BASE
    && cpu_addr <= tcm_pkg::OVF_LAST |=> cpu_rdata[15:1] == 15'h0000)
    else $error("status register upper bits set");
  a_enable_layout: assert property (cpu_rd && cpu_addr == EN
    |=> (cpu_rdata & ~tcm_pkg::ENABLE_MASK) == 16'h0000) else $error("enable bits misplaced");
  a_start_enables: assert property (cpu_wr && cpu_addr == ST && cpu_wdata[0]
    ##2 cpu_rd && cpu_addr == EN |=> cpu_rdata[0]) else $error("start did not enable");
  a_stop_clears: assert property (cpu_wr && cpu_addr == SP && cpu_wdata[0]
    ##2 cpu_rd && cpu_addr == EN |=> !cpu_rdata[0]) else $error("stop did not disable");
  a_rdata_holds: assert property (!cpu_rd |=> $stable(cpu_rdata))
    else $error("read data moved without read");
  a_tout_with_irq: assert property (((channel_timer_output ^ $past(channel_timer_output))
    & ~(channel_interrupt | $past(channel_interrupt))) == 8'h00)
    else $error("output toggled without interrupt");

  c_irq: cover property (|channel_interrupt);
  c_enabled: cover property (cpu_rd && cpu_addr == EN ##1 cpu_rdata != 16'h0000);
  c_tout: cover property (|channel_timer_output);
endmodule

bind tcm_top tcm_assertions u_chk (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr),
  .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
  .channel_interrupt(channel_interrupt), .channel_timer_output(channel_timer_output));

// File: tcm_pin_model.sv
// Timer input pins: idle low, one high pulse of chosen width per request
`timescale 1ns/100ps
module tcm_pin_model (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] fire,
  input  wire logic [3:0] width,
  output logic      [7:0] pin
);
  logic [3:0] left [8];
  always @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_n) begin
        left[i] <= 4'h0;
        pin[i]  <= 1'b0;
      end else if (fire[i] && left[i] == 4'h0) begin
        left[i] <= width;
        pin[i]  <= 1'b1;
      end else if (left[i] != 4'h0) begin
        left[i] <= left[i] - 4'h1;
        pin[i]  <= (left[i] != 4'h1);
      end
    end
  end
endmodule

// File: tcm_top_tb.sv
// Self-checking bench for the timer channel mode block
`timescale 1ns/100ps
module tcm_top_tb;
  localparam logic [19:0] MB = tcm_pkg::MODE_BASE;
  localparam logic [19:0] ST = tcm_pkg::START_ADDR;
  localparam logic [19:0] SP = tcm_pkg::STOP_ADDR;
  localparam logic [19:0] EN = tcm_pkg::ENABLE_ADDR;
  logic        clk       = 1'b0;
  logic        rst_n     = 1'b0;
  logic [19:0] cpu_addr  = 20'h00000;
  logic [15:0] cpu_wdata = 16'h0000;
  logic        cpu_wr    = 1'b0;
  logic        cpu_rd    = 1'b0;
  logic [15:0] cpu_rdata;
  logic [7:0]  pin;
  logic [7:0]  irq;
  logic [7:0]  tout;
  logic [7:0]  fire      = 8'h00;
  logic [3:0]  width     = 4'h2;
  logic [3:0]  pclk      = 4'h0;
  logic        hold      = 1'b0;
  logic        rd_seen   = 1'b0;
  logic [15:0] q_exp[$];
  logic [19:0] q_adr[$];
  int          mismatches = 0;
  int          n_checks   = 0;
  int          cycles     = 0;
  int          irq_cnt [8] = '{default: 0};

  always #4 clk = ~clk;

  tcm_top dut (.clk(clk), .rst_n(rst_n), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata), .timer_input_pin(pin),
    .prescaled_clock_0(pclk[0]), .prescaled_clock_1(pclk[1]),
    .prescaled_clock_2(pclk[2]), .prescaled_clock_3(pclk[3]),
    .channel_interrupt(irq), .channel_timer_output(tout));
  tcm_pin_model u_pin (.clk(clk), .rst_n(rst_n), .fire(fire), .width(width), .pin(pin));

  task automatic test_done();
    if (mismatches == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      mismatches++;
      $display("mismatch %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic wr(input logic [19:0] a, input logic [15:0] d);
    @(posedge clk);
    cpu_addr  <= a;
    cpu_wdata <= d;
    cpu_wr    <= 1'b1;
    @(posedge clk);
    cpu_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [19:0] a, input logic [15:0] e);
    @(posedge clk);
    cpu_addr <= a;
    cpu_rd   <= 1'b1;
    q_exp.push_back(e);
    q_adr.push_back(a);
    @(posedge clk);
    cpu_rd   <= 1'b0;
  endtask

  task automatic pulse(input int ch);
    @(posedge clk);
    width    <= 4'h2 + 4'($urandom_range(0, 6));
    fire[ch] <= 1'b1;
    @(posedge clk);
    fire     <= 8'h00;
    cyc(16);
  endtask

  always @(posedge clk) begin
    pclk    <= 4'($urandom) | {3'h0, hold};
    rd_seen <= cpu_rd;
    cycles  <= cycles + 1;
    for (int i = 0; i < 8; i++) irq_cnt[i] <= irq_cnt[i] + int'(irq[i]);
    if (cycles > 80000) begin
      mismatches++;
      test_done();
    end
  end

  always @(negedge clk) begin
    if (rd_seen) begin
      chk($sformatf("reg %h", q_adr.pop_front()), cpu_rdata, q_exp.pop_front());
    end
  end

  initial begin
    int          b;
    logic [15:0] d;
    logic [15:0] m;
    logic        tog;
    logic [23:0] tm = 24'hc96501;
    logic [5:0]  te = 6'b000101;
    void'($urandom(32'ha251));
    cyc(20);
    rst_n <= 1'b1;
    for (int i = 0; i < 19; i++) rd(MB + 20'(2 * i), 16'h0000);
    rd(20'hf0191, 16'h0000);
    wr(20'hf01b6, 16'hffff);
    rd(20'hf01b6, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom) | 16'h3830;
      m = tcm_pkg::CCS_CH[i] ? tcm_pkg::WMASK_CCS : tcm_pkg::WMASK_PLAIN;
      wr(MB + 20'(2 * i), d);
      rd(MB + 20'(2 * i), d & m);
      wr(MB + 20'(2 * i), 16'h0000);
    end
    tog = 1'b0;
    for (int k = 0; k < 6; k++) begin
      wr(MB + 20'h4, {12'h000, tm[4*k +: 4]});
      b = irq_cnt[2];
      wr(ST, 16'h0004);
      rd(EN, 16'h0004);
      rd(ST, 16'h0000);
      cyc(2);
      tog ^= te[k];
      chk("start irq", 16'(irq_cnt[2] - b), {15'h0, te[k]});
      chk("tout", {15'h0, tout[2]}, {15'h0, tog});
      wr(MB + 20'h4, 16'hffff);
      rd(MB + 20'h4, {12'h000, tm[4*k +: 4]} | 16'h00c0);
      wr(SP, 16'h0004);
      rd(EN, 16'h0000);
      wr(MB + 20'h4, 16'h0000);
    end
    hold <= 1'b1;
    wr(MB + 20'h6, 16'h0144);
    b = irq_cnt[3];
    wr(ST, 16'h0008);
    pulse(3);
    rd(20'hf01a6, 16'h0000);
    cyc(65600);
    rd(20'hf01a6, 16'h0000);
    pulse(3);
    rd(20'hf01a6, 16'h0001);
    pulse(3);
    rd(20'hf01a6, 16'h0000);
    chk("capture irq", 16'(irq_cnt[3] - b), 16'h0003);
    wr(SP, 16'h00ff);
    hold <= 1'b0;
    wr(MB + 20'h2, 16'h0800);
    wr(MB + 20'h6, 16'h0800);
    wr(ST, 16'h0a0a);
    rd(EN, 16'h0a0a);
    rd(ST, 16'h0000);
    wr(SP, 16'h0a0a);
    rd(EN, 16'h0000);
    // Both edges wanted with single-edge trigger: edge code 10
    wr(MB, 16'h0184);
    b = irq_cnt[0];
    wr(ST, 16'h0001);
    pulse(0);
    chk("both edges", 16'(irq_cnt[0] - b), 16'h0002);
    wr(SP, 16'h00ff);
    cyc(4);
    test_done();
  end
endmodule
